// ---- logic/lfm_linefeed_monitor.sv ----
/*
 * Linefeed mode control and line monitor for one channel, with an APB slave.
 * Assumes 8-bit converter codes on adc_in, synchronous to core_clk, and an
 * analog linefeed that obeys the drive enables and the impedance select.
 */
// Function
// - Mode field codes 011 and 111 select ground start
// - Open-lead modes disable that lead, feed other
// - Impedance region uses same open-voltage thresholds
// - Longitudinal current compared to low, high threshold
// - Longitudinal current filtered, ground key debounced
// - Ground key event sets status flag
// - Ground key moves open-lead mode to active
// - Calibration bit self-clears when cycle completes
// - Reset gives open mode, calibration allowed
// - Lead voltages and currents readable in registers
// - Samples are 8-bit converter codes
// - Refresh 800 Hz, ring-ground pair 8 kHz
// - Loop voltage and loop current reported
// - Ground start reports ring voltage and current
// - Excess power forces open mode, raises alarm
`include "lfm_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module lfm_linefeed_monitor #(
    parameter int FAST_CYC = `LFM_FAST_CYC,
    parameter int CAL_CYC  = `LFM_CAL_CYC
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire lfm_pkg::lfm_adc_s adc_in,
    output logic      [2:0]       linefeed_state,
    output logic                  tip_drive_en,
    output logic                  ring_drive_en,
    output logic                  feed_low_imp,
    output logic                  cal_busy,
    output logic                  irq
);

    // ******************************************************************
    // Helpers
    // ******************************************************************

    function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
        abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction

    function automatic logic is_gnd_start(input logic [2:0] m);
        is_gnd_start = (m == lfm_pkg::LFM_MODE_TIP_LEAD_OPEN_MODE) ||
                       (m == lfm_pkg::LFM_MODE_RING_OPEN);
    endfunction

    // ******************************************************************
    // Bus decode
    // ******************************************************************

    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        wr_commit;
    logic        rd_setup;
    logic [1:0]  status_q;
    logic [1:0]  mask_q;
    logic [7:0]  gk_lo_q;
    logic [7:0]  gk_hi_q;
    logic [2:0]  gk_lpf_q;
    logic [7:0]  gk_dbi_q;
    logic [7:0]  voc_lo_q;
    logic [7:0]  voc_hi_q;
    logic [15:0] pwr_th_q;
    lfm_pkg::lfm_mode_e mode_q;
    lfm_pkg::lfm_cal_e  cal_q;
    logic [7:0]  tip_voltage_reading_q;
    logic [7:0]  vring_q;
    logic [7:0]  itip_q;
    logic [7:0]  iring_q;
    logic [7:0]  loop_voltage_reading_q;
    logic [7:0]  iloop_q;
    logic [7:0]  vrg_q;
    logic [7:0]  irg_q;
    logic [15:0] ilong_f_q;
    logic [15:0] power_q;
    logic        region_q;
    logic        unmapped;
    logic [31:0] rd_d;

    assign wr_commit = psel && penable && pready_q && pwrite;
    assign rd_setup  = psel && penable && !pready_q;

    function automatic logic wr_hit(input logic [7:0] off, input logic c,
                                    input logic [7:0] a);
        wr_hit = c && (a == off);
    endfunction

    always_comb
    begin
        rd_d     = 32'h0;
        unmapped = 1'b0;
        if (paddr == `LFM_OFF_CTRL)
            rd_d = {27'h0, (cal_q == lfm_pkg::LFM_CAL_RUN), 1'b0, mode_q};
        else if (paddr == `LFM_OFF_STATUS)
            rd_d = {30'h0, status_q};
        else if (paddr == `LFM_OFF_MASK)
            rd_d = {30'h0, mask_q};
        else if (paddr == `LFM_OFF_GK_LO)
            rd_d = {24'h0, gk_lo_q};
        else if (paddr == `LFM_OFF_GK_HI)
            rd_d = {24'h0, gk_hi_q};
        else if (paddr == `LFM_OFF_GK_LPF)
            rd_d = {29'h0, gk_lpf_q};
        else if (paddr == `LFM_OFF_GK_DBI)
            rd_d = {24'h0, gk_dbi_q};
        else if (paddr == `LFM_OFF_VOC_LO)
            rd_d = {24'h0, voc_lo_q};
        else if (paddr == `LFM_OFF_VOC_HI)
            rd_d = {24'h0, voc_hi_q};
        else if (paddr == `LFM_OFF_PWR_TH)
            rd_d = {16'h0, pwr_th_q};
        else if (paddr == `LFM_OFF_LOOP_VOLTAGE_READING)
            rd_d = {24'h0, loop_voltage_reading_q};
        else if (paddr == `LFM_OFF_TIP_VOLTAGE_READING)
            rd_d = {24'h0, tip_voltage_reading_q};
        else if (paddr == `LFM_OFF_VRING)
            rd_d = {24'h0, vring_q};
        else if (paddr == `LFM_OFF_ILOOP)
            rd_d = {24'h0, iloop_q};
        else if (paddr == `LFM_OFF_VRNG_GND)
            rd_d = {24'h0, vrg_q};
        else if (paddr == `LFM_OFF_IRNG_GND)
            rd_d = {24'h0, irg_q};
        else if (paddr == `LFM_OFF_ILONG)
            rd_d = {16'h0, ilong_f_q};
        else if (paddr == `LFM_OFF_POWER)
            rd_d = {16'h0, power_q};
        else if (paddr == `LFM_OFF_FEED)
            rd_d = {31'h0, region_q};
        else if (paddr == `LFM_OFF_ITIP)
            rd_d = {24'h0, itip_q};
        else if (paddr == `LFM_OFF_IRING)
            rd_d = {24'h0, iring_q};
        else
            unmapped = 1'b1;
    end

    // One wait state: data and error are registered, the write lands at
    // the edge where pready is sampled high.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else if (rd_setup)
        begin
            pready_q  <= 1'b1;
            prdata_q  <= pwrite ? 32'h0 : rd_d;
            pslverr_q <= unmapped;
        end
        else
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ******************************************************************
    // Configuration registers
    // ******************************************************************

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mask_q   <= 2'h0;
            gk_lo_q  <= `LFM_RST_GK_LO;
            gk_hi_q  <= `LFM_RST_GK_HI;
            gk_lpf_q <= `LFM_RST_GK_LPF;
            gk_dbi_q <= `LFM_RST_GK_DBI;
            voc_lo_q <= `LFM_RST_VOC_LO;
            voc_hi_q <= `LFM_RST_VOC_HI;
            pwr_th_q <= `LFM_RST_PWR_TH;
        end
        else
        begin
            if (wr_hit(`LFM_OFF_MASK, wr_commit, paddr))
                mask_q <= pwdata[1:0];
            if (wr_hit(`LFM_OFF_GK_LO, wr_commit, paddr))
                gk_lo_q <= pwdata[7:0];
            if (wr_hit(`LFM_OFF_GK_HI, wr_commit, paddr))
                gk_hi_q <= pwdata[7:0];
            if (wr_hit(`LFM_OFF_GK_LPF, wr_commit, paddr))
                gk_lpf_q <= pwdata[2:0];
            if (wr_hit(`LFM_OFF_GK_DBI, wr_commit, paddr))
                gk_dbi_q <= pwdata[7:0];
            if (wr_hit(`LFM_OFF_VOC_LO, wr_commit, paddr))
                voc_lo_q <= pwdata[7:0];
            if (wr_hit(`LFM_OFF_VOC_HI, wr_commit, paddr))
                voc_hi_q <= pwdata[7:0];
            if (wr_hit(`LFM_OFF_PWR_TH, wr_commit, paddr))
                pwr_th_q <= pwdata[15:0];
        end
    end

    // ******************************************************************
    // Sample timing
    // ******************************************************************

    logic [15:0] fast_cnt_q;
    logic [3:0]  slow_cnt_q;
    logic        fast_tick_q;
    logic        slow_tick_q;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            fast_cnt_q  <= 16'h0;
            slow_cnt_q  <= 4'h0;
            fast_tick_q <= 1'b0;
            slow_tick_q <= 1'b0;
        end
        else
        begin
            fast_tick_q <= 1'b0;
            slow_tick_q <= 1'b0;
            if (fast_cnt_q == 16'(FAST_CYC - 1))
            begin
                fast_cnt_q  <= 16'h0;
                fast_tick_q <= 1'b1;
                if (slow_cnt_q == 4'(`LFM_SLOW_DIV - 1))
                begin
                    slow_cnt_q  <= 4'h0;
                    slow_tick_q <= 1'b1;
                end
                else
                    slow_cnt_q <= slow_cnt_q + 4'h1;
            end
            else
                fast_cnt_q <= fast_cnt_q + 16'h1;
        end
    end

    // ******************************************************************
    // Sampling and derived values
    // ******************************************************************

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tip_voltage_reading_q  <= 8'h0;
            vring_q <= 8'h0;
            itip_q  <= 8'h0;
            iring_q <= 8'h0;
            loop_voltage_reading_q <= 8'h0;
            iloop_q <= 8'h0;
            vrg_q   <= 8'h0;
            irg_q   <= 8'h0;
            power_q <= 16'h0;
        end
        else
        begin
            if (fast_tick_q)
            begin
                vrg_q <= adc_in.v_rng_gnd;
                irg_q <= adc_in.i_rng_gnd;
            end
            if (slow_tick_q)
            begin
                tip_voltage_reading_q  <= adc_in.v_tip;
                vring_q <= adc_in.v_ring;
                itip_q  <= adc_in.i_tip;
                iring_q <= adc_in.i_ring;
                if (is_gnd_start(mode_q))
                begin
                    loop_voltage_reading_q <= adc_in.v_ring;
                    iloop_q <= adc_in.i_ring;
                end
                else
                begin
                    loop_voltage_reading_q <= abs_diff(adc_in.v_tip, adc_in.v_ring);
                    iloop_q <= adc_in.i_tip;
                end
            end
            power_q <= {8'h0, loop_voltage_reading_q} * {8'h0, iloop_q};
        end
    end

    // Impedance region: low impedance once loop voltage drops below the
    // low threshold, back to high once it rises above the high one.
    always_ff @(posedge core_clk)
    begin
        if (rst)
            region_q <= 1'b0;
        else if (!region_q && loop_voltage_reading_q < voc_lo_q)
            region_q <= 1'b1;
        else if (region_q && loop_voltage_reading_q > voc_hi_q)
            region_q <= 1'b0;
    end

    // ******************************************************************
    // Ground key detection
    // ******************************************************************

    logic        gk_raw;
    logic        gk_state_q;
    logic [7:0]  gk_cnt_q;
    logic        gk_event_q;
    logic [15:0] ilong_in;

    assign ilong_in = {adc_in.i_long, 8'h0};

    // Raw decision with hysteresis between the two thresholds.
    assign gk_raw = gk_state_q ? (ilong_f_q[15:8] >= gk_lo_q)
                               : (ilong_f_q[15:8] > gk_hi_q);

    always_ff @(posedge core_clk)
    begin
        if (rst)
            ilong_f_q <= 16'h0;
        else if (slow_tick_q)
            ilong_f_q <= (ilong_in >= ilong_f_q)
                ? ilong_f_q + ((ilong_in - ilong_f_q) >> gk_lpf_q)
                : ilong_f_q - ((ilong_f_q - ilong_in) >> gk_lpf_q);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            gk_state_q <= 1'b0;
            gk_cnt_q   <= 8'h0;
            gk_event_q <= 1'b0;
        end
        else
        begin
            gk_event_q <= 1'b0;
            if (slow_tick_q)
            begin
                if (gk_raw == gk_state_q)
                    gk_cnt_q <= 8'h0;
                else if (gk_cnt_q >= gk_dbi_q)
                begin
                    gk_cnt_q   <= 8'h0;
                    gk_state_q <= gk_raw;
                    gk_event_q <= gk_raw;
                end
                else
                    gk_cnt_q <= gk_cnt_q + 8'h1;
            end
        end
    end

    // ******************************************************************
    // Status, mask and interrupt
    // ******************************************************************

    logic pwr_fault;
    logic [1:0] set_bits;
    logic [1:0] clr_bits;

    assign pwr_fault = (power_q > pwr_th_q) && (mode_q != lfm_pkg::LFM_MODE_OPEN);
    assign set_bits  = {pwr_fault, gk_event_q};
    assign clr_bits  = wr_hit(`LFM_OFF_STATUS, wr_commit, paddr) ? pwdata[1:0] : 2'h0;

    // A set arriving together with its clear wins.
    always_ff @(posedge core_clk)
    begin
        if (rst)
            status_q <= 2'h0;
        else
            status_q <= (status_q & ~clr_bits) | set_bits;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(status_q & mask_q);
    end

    // ******************************************************************
    // Linefeed mode and calibration
    // ******************************************************************

    logic        ctrl_wr;
    logic [15:0] cal_cnt_q;

    assign ctrl_wr = wr_hit(`LFM_OFF_CTRL, wr_commit, paddr);

    // Power fault outranks a software write, which outranks the automatic
    // ground key change.
    always_ff @(posedge core_clk)
    begin
        if (rst)
            mode_q <= lfm_pkg::LFM_MODE_OPEN;
        else if (pwr_fault)
            mode_q <= lfm_pkg::LFM_MODE_OPEN;
        else if (ctrl_wr)
            mode_q <= lfm_pkg::lfm_mode_e'(pwdata[2:0]);
        else if (gk_event_q && mode_q == lfm_pkg::LFM_MODE_TIP_LEAD_OPEN_MODE)
            mode_q <= lfm_pkg::LFM_MODE_FWD;
        else if (gk_event_q && mode_q == lfm_pkg::LFM_MODE_RING_OPEN)
            mode_q <= lfm_pkg::LFM_MODE_REV;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cal_q     <= lfm_pkg::LFM_CAL_IDLE;
            cal_cnt_q <= 16'h0;
        end
        else
        begin
            case (cal_q)
                lfm_pkg::LFM_CAL_IDLE:
                begin
                    cal_cnt_q <= 16'h0;
                    if (ctrl_wr && pwdata[`LFM_CTRL_CAL_BIT])
                        cal_q <= lfm_pkg::LFM_CAL_RUN;
                end
                lfm_pkg::LFM_CAL_RUN:
                begin
                    if (cal_cnt_q == 16'(CAL_CYC - 1))
                        cal_q <= lfm_pkg::LFM_CAL_IDLE;
                    else
                        cal_cnt_q <= cal_cnt_q + 16'h1;
                end
                default:
                    cal_q <= lfm_pkg::LFM_CAL_IDLE;
            endcase
        end
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            linefeed_state <= 3'h0;
            tip_drive_en   <= 1'b0;
            ring_drive_en  <= 1'b0;
            feed_low_imp   <= 1'b0;
            cal_busy       <= 1'b0;
        end
        else
        begin
            linefeed_state <= mode_q;
            tip_drive_en   <= (mode_q != lfm_pkg::LFM_MODE_OPEN) &&
                              (mode_q != lfm_pkg::LFM_MODE_TIP_LEAD_OPEN_MODE);
            ring_drive_en  <= (mode_q != lfm_pkg::LFM_MODE_OPEN) &&
                              (mode_q != lfm_pkg::LFM_MODE_RING_OPEN);
            feed_low_imp   <= region_q;
            cal_busy       <= (cal_q == lfm_pkg::LFM_CAL_RUN);
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

endmodule

`default_nettype wire

// ---- pkg/lfm_defines.svh ----
/*
 * Register offsets, field positions, reset values and timing counts of the
 * linefeed state and line monitor. Assumes a 40 MHz core clock.
 */
`ifndef LFM_DEFINES_SVH
`define LFM_DEFINES_SVH
`define LFM_OFF_CTRL        8'h00
`define LFM_OFF_STATUS      8'h04
`define LFM_OFF_MASK        8'h08
`define LFM_OFF_GK_LO       8'h0c
`define LFM_OFF_GK_HI       8'h10
`define LFM_OFF_GK_LPF      8'h14
`define LFM_OFF_GK_DBI      8'h18
`define LFM_OFF_VOC_LO      8'h1c
`define LFM_OFF_VOC_HI      8'h20
`define LFM_OFF_PWR_TH      8'h24
`define LFM_OFF_LOOP_VOLTAGE_READING       8'h28
`define LFM_OFF_TIP_VOLTAGE_READING        8'h2c
`define LFM_OFF_VRING       8'h30
`define LFM_OFF_ILOOP       8'h34
`define LFM_OFF_VRNG_GND    8'h38
`define LFM_OFF_IRNG_GND    8'h3c
`define LFM_OFF_ILONG       8'h40
`define LFM_OFF_POWER       8'h44
`define LFM_OFF_FEED        8'h48
`define LFM_OFF_ITIP        8'h4c
`define LFM_OFF_IRING       8'h50
`define LFM_CTRL_MODE_LSB   0
`define LFM_CTRL_CAL_BIT    4
`define LFM_ST_GK_BIT       0
`define LFM_ST_PWR_BIT      1
`define LFM_RST_GK_LO       8'h20
`define LFM_RST_GK_HI       8'h40
`define LFM_RST_GK_LPF      3'h2
`define LFM_RST_GK_DBI      8'h04
`define LFM_RST_VOC_LO      8'h60
`define LFM_RST_VOC_HI      8'h80
`define LFM_RST_PWR_TH      16'hf000
`define LFM_CLK_HZ          40000000
`define LFM_FAST_HZ         8000
`define LFM_SLOW_HZ         800
`define LFM_FAST_CYC        (`LFM_CLK_HZ / `LFM_FAST_HZ)
`define LFM_SLOW_DIV        (`LFM_FAST_HZ / `LFM_SLOW_HZ)
`define LFM_CAL_TIME_US     100
`define LFM_CAL_CYC         (`LFM_CAL_TIME_US * (`LFM_CLK_HZ / 1000000))
`endif

// ---- pkg/lfm_pkg.sv ----
/*
 * Types of the linefeed state and line monitor.
 * Assumes nothing of its surroundings.
 */
package lfm_pkg;
    typedef enum logic [2:0] {
        LFM_MODE_OPEN     = 3'h0,
        LFM_MODE_FWD      = 3'h1,
        LFM_MODE_TIP_LEAD_OPEN_MODE = 3'h3,
        LFM_MODE_REV      = 3'h5,
        LFM_MODE_RING_OPEN = 3'h7
    } lfm_mode_e;
    typedef enum logic [1:0] {
        LFM_CAL_IDLE = 2'h1,
        LFM_CAL_RUN  = 2'h2
    } lfm_cal_e;
    typedef struct packed {
        logic [7:0] v_tip;
        logic [7:0] v_ring;
        logic [7:0] i_tip;
        logic [7:0] i_ring;
        logic [7:0] i_long;
        logic [7:0] v_rng_gnd;
        logic [7:0] i_rng_gnd;
    } lfm_adc_s;
endpackage

// ---- bench/lfm_monitor_properties.sv ----
/* Port checker of the linefeed monitor.
   Assumes it is bound to lfm_linefeed_monitor. */
`timescale 1ns/1ps
`default_nettype none
module lfm_monitor_properties #(
    parameter int CAL_CYC = 10
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [2:0] linefeed_state,
    input wire logic       tip_drive_en,
    input wire logic       ring_drive_en,
    input wire logic       cal_busy,
    input wire logic       irq
);
    int unsigned cal_cnt_q;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    always_ff @(posedge core_clk)
        if (rst || !cal_busy)
            cal_cnt_q <= 0;
        else
            cal_cnt_q <= cal_cnt_q + 1;
    chk_pready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_tip_lead_open_mode_lead: assert property (linefeed_state == 3'h3 && $past(linefeed_state) == 3'h3
        |-> !tip_drive_en && ring_drive_en)
        else $error("tip_lead_open_mode mode drives wrong leads");
    chk_ring_open_lead: assert property (linefeed_state == 3'h7 && $past(linefeed_state) == 3'h7
        |-> tip_drive_en && !ring_drive_en)
        else $error("ring open mode drives wrong leads");
    chk_active_leads: assert property ((linefeed_state == 3'h1 || linefeed_state == 3'h5)
        && $stable(linefeed_state) |-> tip_drive_en && ring_drive_en)
        else $error("active mode leaves a lead open");
    chk_open_leads: assert property (linefeed_state == 3'h0 && $stable(linefeed_state)
        |-> !tip_drive_en && !ring_drive_en)
        else $error("open mode drives a lead");
    chk_reset_open: assert property (disable iff (1'b0) $fell(rst)
        |-> linefeed_state == 3'h0 && !irq && !cal_busy)
        else $error("not open and idle after reset");
    chk_cal_bound: assert property (cal_cnt_q <= CAL_CYC)
        else $error("calibration does not finish");
    chk_cal_length: assert property ($fell(cal_busy) |-> cal_cnt_q == CAL_CYC)
        else $error("calibration has the wrong length");
    cover property ($rose(cal_busy));
    cover property (linefeed_state == 3'h1 && $past(linefeed_state) == 3'h3);
    cover property (linefeed_state == 3'h0 && $past(linefeed_state) == 3'h1);
endmodule
bind lfm_linefeed_monitor lfm_monitor_properties #(.CAL_CYC(CAL_CYC)) i_chk (.core_clk,
    .rst, .psel, .penable, .pready, .pslverr, .linefeed_state, .tip_drive_en, .ring_drive_en,
    .cal_busy, .irq);
`default_nettype wire

// ---- bench/lfm_line_model.sv ----
/* Subscriber line with customer equipment, as seen by the converter.
   Assumes the bench drives the ground key and the ring-ground phase. */
`timescale 1ns/1ps
`default_nettype none
module lfm_line_model (
    input  wire logic          gnd_key,
    input  wire logic          alt,
    output var lfm_pkg::lfm_adc_s adc_in
);
    // Grounding the active lead shows as a large longitudinal current.
    always_comb
    begin
        adc_in.v_tip     = 8'h50;
        adc_in.v_ring    = 8'h20;
        adc_in.i_tip     = 8'h10;
        adc_in.i_ring    = 8'h08;
        adc_in.i_long    = gnd_key ? 8'hf0 : 8'h00;
        adc_in.v_rng_gnd = alt ? 8'h44 : 8'h33;
        adc_in.i_rng_gnd = alt ? 8'h66 : 8'h55;
    end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
/* Self-checking bench of the linefeed monitor.
   Assumes the line model on adc_in and a 40 MHz clock. */
`include "lfm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic              core_clk;
    logic              rst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    lfm_pkg::lfm_adc_s adc_in;
    logic [2:0]        linefeed_state;
    logic              tip_drive_en;
    logic              ring_drive_en;
    logic              feed_low_imp;
    logic              cal_busy;
    logic              irq;
    logic              gnd_key;
    logic              alt;
    logic [31:0]       rd;
    logic              err;
    int                miscompares;
    int                checked;
    int                n;
    lfm_linefeed_monitor #(.FAST_CYC(20), .CAL_CYC(10)) i_dut (.core_clk, .rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .adc_in,
        .linefeed_state, .tip_drive_en, .ring_drive_en, .feed_low_imp, .cal_busy, .irq);
    lfm_line_model i_line (.gnd_key, .alt, .adc_in);
    // ****************************************
    // Bus cycles and comparison.
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
            miscompares++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 6000)
        begin
            @(posedge core_clk);
            n++;
        end
    endtask
    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset;
        chk("state", linefeed_state, 3'h0);
        chk("leads", {tip_drive_en, ring_drive_en, irq}, 3'h0);
        rdc(`LFM_OFF_CTRL, 32'h0, "ctrl");
        rdc(`LFM_OFF_GK_LO, 32'h20, "gk_lo");
        rdc(`LFM_OFF_GK_HI, 32'h40, "gk_hi");
        rdc(`LFM_OFF_GK_LPF, 32'h2, "gk_lpf");
        rdc(`LFM_OFF_GK_DBI, 32'h4, "gk_dbi");
        rdc(`LFM_OFF_VOC_LO, 32'h60, "voc_lo");
        rdc(`LFM_OFF_VOC_HI, 32'h80, "voc_hi");
        rdc(`LFM_OFF_PWR_TH, 32'hf000, "pwr_th");
    endtask
    task automatic t_cal;
        wr(`LFM_OFF_CTRL, 32'h10);
        repeat (2) @(posedge core_clk);
        chk("cal_busy", cal_busy, 1'b1);
        rdc(`LFM_OFF_CTRL, 32'h10, "cal_run");
        n = 0;
        while (cal_busy !== 1'b0 && n < 100)
        begin
            @(posedge core_clk);
            n++;
        end
        rdc(`LFM_OFF_CTRL, 32'h0, "cal_done");
    endtask
    task automatic t_modes;
        logic [2:0] m [4] = '{3'h1, 3'h3, 3'h7, 3'h5};
        logic       gs;
        for (int k = 0; k < 4; k++)
        begin
            gs = m[k] == 3'h3 || m[k] == 3'h7;
            wr(`LFM_OFF_CTRL, {29'h0, m[k]});
            repeat (405) @(posedge core_clk);
            chk("state", linefeed_state, m[k]);
            chk("tip_en", tip_drive_en, m[k] != 3'h3);
            chk("ring_en", ring_drive_en, m[k] != 3'h7);
            chk("low_imp", feed_low_imp, 1'b1);
            rdc(`LFM_OFF_LOOP_VOLTAGE_READING, gs ? 32'h20 : 32'h30, "loop_voltage_reading");
            rdc(`LFM_OFF_ILOOP, gs ? 32'h08 : 32'h10, "iloop");
        end
        rdc(`LFM_OFF_TIP_VOLTAGE_READING, 32'h50, "tip_voltage_reading");
        rdc(`LFM_OFF_VRING, 32'h20, "vring");
        rdc(`LFM_OFF_ITIP, 32'h10, "itip");
        rdc(`LFM_OFF_IRING, 32'h08, "iring");
        wr(`LFM_OFF_TIP_VOLTAGE_READING, 32'h0);
        rdc(`LFM_OFF_TIP_VOLTAGE_READING, 32'h50, "tip_voltage_reading_ro");
        alt <= 1'b1;
        repeat (45) @(posedge core_clk);
        rdc(`LFM_OFF_VRNG_GND, 32'h44, "vrng_gnd");
        rdc(`LFM_OFF_IRNG_GND, 32'h66, "irng_gnd");
        wr(`LFM_OFF_VOC_LO, 32'h10);
        wr(`LFM_OFF_VOC_HI, 32'h18);
        repeat (405) @(posedge core_clk);
        chk("high_imp", feed_low_imp, 1'b0);
    endtask
    task automatic t_gkey(input logic [2:0] m, input logic [2:0] act);
        wr(`LFM_OFF_MASK, 32'h1);
        wr(`LFM_OFF_CTRL, {29'h0, m});
        gnd_key <= 1'b1;
        wait_irq;
        chk("gk_wait", n >= 800 && n < 6000, 1'b1);
        rdc(`LFM_OFF_STATUS, 32'h1, "gk_flag");
        chk("auto_mode", linefeed_state, act);
        repeat (300) @(posedge core_clk);
        rdc(`LFM_OFF_STATUS, 32'h1, "gk_hold");
        chk("mode_hold", linefeed_state, act);
        wr(`LFM_OFF_STATUS, 32'h1);
        gnd_key <= 1'b0;
        repeat (4000) @(posedge core_clk);
        rdc(`LFM_OFF_STATUS, 32'h0, "gk_clear");
        chk("irq_off", irq, 1'b0);
    endtask
    task automatic t_power;
        wr(`LFM_OFF_CTRL, 32'h1);
        wr(`LFM_OFF_MASK, 32'h2);
        wr(`LFM_OFF_PWR_TH, 32'h100);
        wait_irq;
        chk("pwr_open", linefeed_state, 3'h0);
        rdc(`LFM_OFF_STATUS, 32'h2, "pwr_alarm");
        apb(1'b0, 8'hfc, 32'h0);
        chk("unmapped", {err, rd}, {1'b1, 32'h0});
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial
    begin
        #(25 * 60000);
        miscompares++;
        give_verdict;
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, gnd_key, alt} = '0;
        miscompares = 0;
        checked = 0;
        rst = 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset;
        t_cal;
        t_modes;
        t_gkey(3'h3, 3'h1);
        t_gkey(3'h7, 3'h5);
        t_power;
        give_verdict;
    end
endmodule
`default_nettype wire
